// ---- verilog/wdcsp_regs.svh ----
// Register map, field positions, reset values and timing counts
`ifndef WDCSP_REGS_SVH
`define WDCSP_REGS_SVH

// Byte addresses on the register bus
`define WDCSP_A_REFRESH 8'h00
`define WDCSP_A_START 8'h04
`define WDCSP_A_PROT 8'h08
`define WDCSP_A_CM1 8'h0c
`define WDCSP_A_PM1 8'h10
`define WDCSP_A_STAT 8'h14
`define WDCSP_A_IRQ_STS 8'h18
`define WDCSP_A_IRQ_MSK 8'h1c
`define WDCSP_A_OPT 8'h20

// Field positions
`define WDCSP_PROT_BIT 7
`define WDCSP_CM_STOP_BIT 0
`define WDCSP_CM_OSC_BIT 4
`define WDCSP_PM_UFA_BIT 2
`define WDCSP_OPT_PROT_BIT 7
`define WDCSP_OPT_START_BIT 0
`define WDCSP_IRQ_UFL 0
`define WDCSP_IRQ_STOPREF 1
`define WDCSP_STAT_RUN 16
`define WDCSP_STAT_PROT 17
`define WDCSP_STAT_ARM 18

// Values
`define WDCSP_REFRESH_FIRST 8'h00
`define WDCSP_REFRESH_SECOND 8'hff
`define WDCSP_RELOAD 12'hfff
`define WDCSP_OPT_HOME 16'hffff
`define WDCSP_OSC_STOP_RST 1'b0
`define WDCSP_UFA_RST 1'b0
`define WDCSP_RESP_OKAY 2'b00
`define WDCSP_RESP_SLVERR 2'b10

// Timing: slow oscillator period against the system clock
`define WDCSP_OSC_PERIOD_NS 8000
`define WDCSP_CLK_PERIOD_NS 10
`define WDCSP_OSC_CYC (`WDCSP_OSC_PERIOD_NS / `WDCSP_CLK_PERIOD_NS)

`endif

// ---- verilog/wdcsp_pkg.sv ----
// Types shared by the watchdog design
package wdcsp_pkg;

   // Counter run state, one-hot
   typedef enum logic [1:0] {
      WDCSP_IDLE = 2'b01,
      WDCSP_RUN = 2'b10
   } wdcsp_run_t;

endpackage

// ---- verilog/wdcsp_top.sv ----
// Watchdog timer with count source protection, AXI4-Lite registers
//
// Operation
// RL1: Protected counting paced by slow oscillator, not by CPU clock state.
// RL2: Count down once per oscillator tick; period is 4096 ticks.
// RL3: Start option 1: stay stopped after reset until start register write.
// RL4: Start option 0: begin counting right after reset release.
// RL5: Refresh by writing 00h then FFh; reload also on reset, underflow.
// RL6: Protected underflow gives chip watchdog reset, never an interrupt.
// RL7: Once protected, keep counting in wait mode and refuse stop mode.
// RL8: Setting protection enable loads counter with 0FFFh.
// RL9: Setting protection enable clears oscillator stop bit.
// RL10: Setting protection enable sets underflow action to reset.
// RL11: While protected, stop mode entry bit writes are ignored.
// RL12: While protected, oscillator stop bit writes are ignored.
// RL13: Protect option 0 forces protection enable on out of reset.
// RL14: Protect option is option byte bit 7, read-only to software.
// RL15: Start option is option byte bit 0, read-only to software.
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "wdcsp_regs.svh"

module wdcsp_top #(
   parameter int OSC_DIV = `WDCSP_OSC_CYC
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] option_function_byte,
   input wire logic wait_mode,
   input wire logic wake,
   output logic wdt_rst_q,
   output logic stop_mode_q,
   output logic osc_run_q,
   output logic irq_q
);

   ////////////////////////////////////////////////////////////////////
   // Declarations

   logic aw_got_q;
   logic w_got_q;
   logic [7:0] waddr_q;
   logic [7:0] wbyte_q;
   logic [1:0] wbits_q;
   logic wlane_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic awready_q;
   logic wready_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_d;

   logic wr_go;
   logic wr_lane;
   logic wr_refresh;
   logic wr_start;
   logic wr_prot;
   logic wr_cm1;
   logic wr_pm1;
   logic wr_sts;
   logic wr_msk;

   logic [7:0] opt_q;
   logic boot_q;
   logic prot_q;
   logic prot_set;
   logic prot_rise;
   logic arm_q;
   logic refresh_ok;
   logic osc_stop_q;
   logic ufa_q;
   logic stop_q;
   logic stop_refused;
   wdcsp_pkg::wdcsp_run_t run_q;
   logic [15:0] div_q;
   logic osc_tick;
   logic cnt_en;
   logic [11:0] cnt_q;
   logic ufl;
   logic [1:0] sts_q;
   logic [1:0] msk_q;
   logic [1:0] sts_set;

   ////////////////////////////////////////////////////////////////////
   // Address decode shared by the write and read paths

   function automatic logic mapped(input logic [7:0] a);
      unique case (a)
         `WDCSP_A_REFRESH,
         `WDCSP_A_START,
         `WDCSP_A_PROT,
         `WDCSP_A_CM1,
         `WDCSP_A_PM1,
         `WDCSP_A_STAT,
         `WDCSP_A_IRQ_STS,
         `WDCSP_A_IRQ_MSK,
         `WDCSP_A_OPT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel: address and data in either order

   // Write performed once both halves are held and no response pends
   assign wr_go = aw_got_q & w_got_q & ~bvalid_q;

   // Address holder; ready drops while one address is pending
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         aw_got_q <= 1'b0;
         awready_q <= 1'b0;
         waddr_q <= 8'h00;
      end else if (s_axi_awvalid && awready_q) begin
         aw_got_q <= 1'b1;
         awready_q <= 1'b0;
         waddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_got_q <= 1'b0;
      end else if (!aw_got_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   // Data holder; only byte lane 0 carries register bits
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         w_got_q <= 1'b0;
         wready_q <= 1'b0;
         wbyte_q <= 8'h00;
         wbits_q <= 2'h0;
         wlane_q <= 1'b0;
      end else if (s_axi_wvalid && wready_q) begin
         w_got_q <= 1'b1;
         wready_q <= 1'b0;
         wbyte_q <= s_axi_wdata[7:0];
         wbits_q <= s_axi_wdata[1:0];
         wlane_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_got_q <= 1'b0;
      end else if (!w_got_q && !bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   // Response; unmapped addresses answer SLVERR and change nothing
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         bvalid_q <= 1'b0;
         bresp_q <= `WDCSP_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= mapped(waddr_q) ? `WDCSP_RESP_OKAY
                                    : `WDCSP_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Register write strobes, lane 0 must be enabled
   assign wr_lane = wr_go & wlane_q;
   assign wr_refresh = wr_lane & (waddr_q == `WDCSP_A_REFRESH);
   assign wr_start = wr_lane & (waddr_q == `WDCSP_A_START);
   assign wr_prot = wr_lane & (waddr_q == `WDCSP_A_PROT);
   assign wr_cm1 = wr_lane & (waddr_q == `WDCSP_A_CM1);
   assign wr_pm1 = wr_lane & (waddr_q == `WDCSP_A_PM1);
   assign wr_sts = wr_lane & (waddr_q == `WDCSP_A_IRQ_STS);
   assign wr_msk = wr_lane & (waddr_q == `WDCSP_A_IRQ_MSK);

   ////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel

   // Read data mux; option byte has no write path at all
   always_comb begin
      rdata_d = 32'h00000000;
      unique case (s_axi_araddr)
         `WDCSP_A_PROT: rdata_d[`WDCSP_PROT_BIT] = prot_q;
         `WDCSP_A_CM1: begin
            rdata_d[`WDCSP_CM_STOP_BIT] = stop_q;
            rdata_d[`WDCSP_CM_OSC_BIT] = osc_stop_q;
         end
         `WDCSP_A_PM1: rdata_d[`WDCSP_PM_UFA_BIT] = ufa_q;
         `WDCSP_A_STAT: begin
            rdata_d[11:0] = cnt_q;
            rdata_d[`WDCSP_STAT_RUN] = (run_q == wdcsp_pkg::WDCSP_RUN);
            rdata_d[`WDCSP_STAT_PROT] = prot_q;
            rdata_d[`WDCSP_STAT_ARM] = arm_q;
         end
         `WDCSP_A_IRQ_STS: rdata_d[1:0] = sts_q;
         `WDCSP_A_IRQ_MSK: rdata_d[1:0] = msk_q;
         `WDCSP_A_OPT: rdata_d[7:0] = opt_q; // RL14 RL15
         default: rdata_d = 32'h00000000;
      endcase
   end

   // One read at a time; data captured with the address
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `WDCSP_RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rdata_d;
         rresp_q <= mapped(s_axi_araddr) ? `WDCSP_RESP_OKAY
                                         : `WDCSP_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Option byte capture at reset

   // Caught while reset is held; flash straps are stable by then
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         opt_q <= option_function_byte; // RL14 RL15
      end
   end

   // First cycle after release applies the options
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Protection enable and the bits it forces

   // Set by software or by the option; only reset clears it
   assign prot_set = (wr_prot & wbyte_q[`WDCSP_PROT_BIT])
                   | (boot_q & ~opt_q[`WDCSP_OPT_PROT_BIT]); // RL13
   assign prot_rise = prot_set & ~prot_q;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         prot_q <= 1'b0;
      end else if (prot_set) begin
         prot_q <= 1'b1; // RL13
      end
   end

   // Oscillator stop bit, held clear while protected
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         osc_stop_q <= `WDCSP_OSC_STOP_RST;
      end else if (prot_rise) begin
         osc_stop_q <= 1'b0; // RL9
      end else if (wr_cm1 && !prot_q) begin
         osc_stop_q <= wbyte_q[`WDCSP_CM_OSC_BIT]; // RL12
      end
   end

   // Underflow action: 1 gives reset, 0 only flags the event
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ufa_q <= `WDCSP_UFA_RST;
      end else if (prot_rise) begin
         ufa_q <= 1'b1; // RL10
      end else if (wr_pm1 && !prot_q) begin
         ufa_q <= wbyte_q[`WDCSP_PM_UFA_BIT];
      end
   end

   // Stop mode request; a wake event ends it
   assign stop_refused = wr_cm1 & prot_q & wbyte_q[`WDCSP_CM_STOP_BIT];

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         stop_q <= 1'b0;
      end else if (wake) begin
         stop_q <= 1'b0;
      end else if (wr_cm1 && !prot_q) begin
         stop_q <= wbyte_q[`WDCSP_CM_STOP_BIT]; // RL11 RL7
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Refresh sequence

   // Any other value to the refresh register disarms the sequence
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         arm_q <= 1'b0;
      end else if (wr_refresh) begin
         arm_q <= (wbyte_q == `WDCSP_REFRESH_FIRST); // RL5
      end
   end

   assign refresh_ok = wr_refresh & arm_q
                     & (wbyte_q == `WDCSP_REFRESH_SECOND); // RL5

   ////////////////////////////////////////////////////////////////////
   // Run control

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         run_q <= wdcsp_pkg::WDCSP_IDLE;
      end else begin
         unique case (run_q)
            wdcsp_pkg::WDCSP_IDLE: begin
               if (boot_q && !opt_q[`WDCSP_OPT_START_BIT]) begin
                  run_q <= wdcsp_pkg::WDCSP_RUN; // RL4
               end else if (wr_start) begin
                  run_q <= wdcsp_pkg::WDCSP_RUN; // RL3
               end
            end
            wdcsp_pkg::WDCSP_RUN: run_q <= wdcsp_pkg::WDCSP_RUN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Slow oscillator and prescaler

   // Divider stands for the slow oscillator; cleared while stopped or idle
   assign osc_tick = ~osc_stop_q & (div_q == 16'(OSC_DIV - 1));

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         div_q <= 16'h0000;
      end else if (run_q != wdcsp_pkg::WDCSP_RUN || osc_stop_q) begin
         div_q <= 16'h0000; // RL3
      end else if (osc_tick) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Watchdog counter

   // Protected counting ignores wait and stop; unprotected holds there
   assign cnt_en = (run_q == wdcsp_pkg::WDCSP_RUN) & osc_tick
                 & (prot_q | ~(wait_mode | stop_q)); // RL1 RL7
   assign ufl = cnt_en & (cnt_q == 12'h000);

   // Reload wins over a tick in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cnt_q <= `WDCSP_RELOAD; // RL5
      end else if (prot_rise) begin
         cnt_q <= `WDCSP_RELOAD; // RL8
      end else if (refresh_ok) begin
         cnt_q <= `WDCSP_RELOAD; // RL5
      end else if (ufl) begin
         cnt_q <= `WDCSP_RELOAD; // RL5
      end else if (cnt_en) begin
         cnt_q <= cnt_q - 12'h001; // RL2
      end
   end

   // Chip reset pulse on underflow when the action selects it
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wdt_rst_q <= 1'b0;
      end else begin
         wdt_rst_q <= ufl & ufa_q; // RL6
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Event status and interrupt

   // Protected underflow resets the chip, so it never flags here
   assign sts_set[`WDCSP_IRQ_UFL] = ufl & ~prot_q; // RL6
   assign sts_set[`WDCSP_IRQ_STOPREF] = stop_refused; // RL7

   // Write one to clear; a new event in the same cycle wins
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         sts_q <= 2'h0;
      end else if (wr_sts) begin
         sts_q <= (sts_q & ~wbits_q) | sts_set;
      end else begin
         sts_q <= sts_q | sts_set;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         msk_q <= 2'h0;
      end else if (wr_msk) begin
         msk_q <= wbits_q;
      end
   end

   // Registered, so it lags the status bit by one cycle
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(sts_q & msk_q);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Level outputs

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         stop_mode_q <= 1'b0;
         osc_run_q <= 1'b0;
      end else begin
         stop_mode_q <= stop_q;
         osc_run_q <= ~osc_stop_q; // RL9 RL12
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

endmodule // wdcsp_top

// ---- test/wdcsp_assertions.sv ----
// Port-level concurrent checks for the protected watchdog
`timescale 1ns/1ns
`include "wdcsp_regs.svh"

module wdcsp_assertions #(
   parameter int OSC_DIV = 2
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wdt_rst_q,
   input wire logic stop_mode_q,
   input wire logic osc_run_q
);
   localparam int PER = 4096 * OSC_DIV;
   logic [7:0] aw_q;
   logic [7:0] w_q;
   logic prot_q;
   logic seen_q;
   int gap_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   ////////////////////////////////////////////////////////////////////////
   // Last write seen; only software-set protection is tracked here
   always_ff @(posedge sys_clk) begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[7:0];
   end
   always_ff @(posedge sys_clk) begin
      if (!nrst) prot_q <= 1'h0;
      else if (s_axi_bvalid && aw_q == `WDCSP_A_PROT && w_q[7]) prot_q <= 1'h1;
   end
   // Cycles between resets; any write may be a refresh, so it restarts
   always_ff @(posedge sys_clk) begin
      if (!nrst || s_axi_bvalid) begin
         gap_q <= 0;
         seen_q <= 1'h0;
      end else if (wdt_rst_q) begin
         gap_q <= 0;
         seen_q <= 1'h1;
      end else gap_q <= gap_q + 1;
   end

   ////////////////////////////////////////////////////////////////////////
   aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=>
      !s_axi_awready) else $error("awready not dropped after take");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
   rd_slverr_a: assert property (s_axi_arvalid && s_axi_arready &&
      (s_axi_araddr > `WDCSP_A_OPT || s_axi_araddr[1:0] != 2'h0) |=>
      s_axi_rvalid && s_axi_rresp == `WDCSP_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   stop_lock_a: assert property (prot_q && !stop_mode_q |=> !stop_mode_q)
      else $error("stop mode entered while protected");
   osc_lock_a: assert property (prot_q |-> osc_run_q)
      else $error("slow oscillator off while protected");
   rst_pulse_a: assert property (wdt_rst_q |=> !wdt_rst_q)
      else $error("watchdog reset longer than a pulse");
   rst_period_a: assert property (wdt_rst_q && seen_q |->
      gap_q >= PER - 3 && gap_q <= PER + 1) else $error("wrong timeout");
endmodule // wdcsp_assertions

bind wdcsp_top wdcsp_assertions #(.OSC_DIV(OSC_DIV)) u_chk (
   .sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .wdt_rst_q(wdt_rst_q),
   .stop_mode_q(stop_mode_q), .osc_run_q(osc_run_q));

// ---- test/tb_top.sv ----
// Self-checking bench for the protected watchdog
`timescale 1ns/1ns
`include "wdcsp_regs.svh"

module tb_top;
   // Short divider keeps a full timeout near eight thousand cycles
   localparam int DIV = 2;
   localparam int PER = 4096 * DIV;
   logic sys_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, wait_mode, wake;
   logic wdt_rst, stop_mode, osc_run, irq;
   logic [7:0] awaddr, araddr, opt;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   int n_rst = 0;

   wdcsp_top #(.OSC_DIV(DIV)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .option_function_byte(opt),
      .wait_mode(wait_mode), .wake(wake), .wdt_rst_q(wdt_rst),
      .stop_mode_q(stop_mode), .osc_run_q(osc_run), .irq_q(irq));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Reset pulse tally and hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (wdt_rst === 1'h1) n_rst <= n_rst + 1;
      if (cyc == 40000) begin
         n_errors = n_errors + 1;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task test_done;
      if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Address and data offered together, each dropped once taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      rs = bresp;
      bready <= 1'h0;
   endtask
   task rdr(input logic [7:0] a);
      @(posedge sys_clk);
      araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rd = rdata; rs = rresp;
      rready <= 1'h0;
   endtask
   // Options must be steady at the last low edge
   task rst(input logic [7:0] o);
      @(posedge sys_clk);
      nrst <= 1'h0; opt <= o;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'h1;
      repeat (4) @(posedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task t_stopped;
      logic [11:0] c1;
      rst(8'hff);
      rdr(`WDCSP_A_STAT); chk("held", rd[16], 1'h0);
      wr(`WDCSP_A_OPT, 32'h0); rdr(`WDCSP_A_OPT);
      chk("opt_ro", rd[7:0], 8'hff);
      rdr(8'h40); chk("unmap", rs, `WDCSP_RESP_SLVERR);
      wr(`WDCSP_A_START, 32'h1); rdr(`WDCSP_A_STAT);
      chk("started", rd[16], 1'h1);
      c1 = rd[11:0];
      repeat (200) @(posedge sys_clk);
      rdr(`WDCSP_A_STAT);
      chk("rate", (c1 - rd[11:0]) inside {[12'h64:12'h68]}, 1'h1);
   endtask
   task t_unprot_cm;
      // Level outputs follow the register one edge after the answer
      wr(`WDCSP_A_CM1, 32'h1); @(posedge sys_clk);
      chk("stop", stop_mode, 1'h1);
      @(posedge sys_clk) wake <= 1'h1;
      @(posedge sys_clk) wake <= 1'h0;
      repeat (2) @(posedge sys_clk);
      chk("woke", stop_mode, 1'h0);
      rdr(`WDCSP_A_PM1); chk("ufa_rst", rd[2], 1'h0);
      wr(`WDCSP_A_CM1, 32'h10); @(posedge sys_clk);
      chk("osc_off", osc_run, 1'h0);
   endtask
   task t_protect;
      wr(`WDCSP_A_PROT, 32'h80); @(posedge sys_clk);
      chk("osc_on", osc_run, 1'h1);
      rdr(`WDCSP_A_STAT); chk("prot", rd[17], 1'h1);
      chk("load", rd[11:0] >= 12'hff0, 1'h1);
      wr(`WDCSP_A_PM1, 32'h0); rdr(`WDCSP_A_PM1);
      chk("ufa_set", rd[2], 1'h1);
      wr(`WDCSP_A_CM1, 32'h11); @(posedge sys_clk);
      chk("stop_lock", stop_mode, 1'h0);
      chk("osc_lock", osc_run, 1'h1);
      rdr(`WDCSP_A_IRQ_STS); chk("refused", rd[1], 1'h1);
      chk("irq_masked", irq, 1'h0);
      wr(`WDCSP_A_IRQ_MSK, 32'h2); repeat (2) @(posedge sys_clk);
      chk("irq_on", irq, 1'h1);
      wr(`WDCSP_A_IRQ_STS, 32'h2); repeat (2) @(posedge sys_clk);
      chk("irq_clr", irq, 1'h0);
   endtask
   task t_timeout;
      logic [11:0] c1;
      int b;
      wait_mode <= 1'h1;
      rdr(`WDCSP_A_STAT); c1 = rd[11:0];
      repeat (100) @(posedge sys_clk);
      rdr(`WDCSP_A_STAT); chk("wait_run", rd[11:0] < c1, 1'h1);
      wr(`WDCSP_A_REFRESH, 32'h0); wr(`WDCSP_A_REFRESH, 32'hff);
      b = n_rst;
      rdr(`WDCSP_A_STAT); chk("refresh", rd[11:0] >= 12'hff0, 1'h1);
      repeat (PER - 300) @(posedge sys_clk);
      chk("early", n_rst - b, 32'h0);
      repeat (400) @(posedge sys_clk);
      chk("uf_rst", n_rst - b, 32'h1);
      repeat (PER) @(posedge sys_clk);
      chk("uf_again", n_rst - b, 32'h2);
      rdr(`WDCSP_A_IRQ_STS); chk("no_irq", rd[0], 1'h0);
      wait_mode <= 1'h0;
   endtask
   task t_opt_prot;
      rst(8'h7e);
      rdr(`WDCSP_A_STAT); chk("boot_prot", rd[17], 1'h1);
      chk("auto_run", rd[16], 1'h1);
      rdr(`WDCSP_A_OPT); chk("opt", rd[7:0], 8'h7e);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'h0; opt = 8'hff; awaddr = 8'h0; araddr = 8'h0;
      wdata = 32'h0; awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0;
      arvalid = 1'h0; rready = 1'h0; wait_mode = 1'h0; wake = 1'h0;
      t_stopped();
      t_unprot_cm();
      t_protect();
      t_timeout();
      t_opt_prot();
      test_done();
   end
endmodule // tb_top
